// [rtl/mpdio_port_top.sv]
// Register access over APB was decided locally.
`timescale 1ns/1ns
module mpdio_port_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] cfgWord,
  output logic replModeActive,
  output logic extReq,
  output logic extWrite,
  output logic [31:0] extAddr,
  output logic [31:0] extWdata,
  output logic [3:0] extStrb,
  input wire logic extAck,
  input wire logic [31:0] extRdata,
  input wire logic [55:0] pinIn,
  output logic [55:0] pinOut,
  output logic [55:0] pinOeN,
  input wire logic [55:0] busOut,
  input wire logic [55:0] busOeN,
  output logic [55:0] busIn
);
  mpdio_pin_if pif ();
  mpdio_pkg::mpdio_state_e state_r;
  logic cfgDone_r;
  logic replMode_r;
  logic [1:0] waitCnt_r;
  logic localOk_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic extReq_r;
  logic extWrite_r;
  logic [31:0] extAddr_r;
  logic [31:0] extWdata_r;
  logic [3:0] extStrb_r;
  logic [55:0] func_r;
  logic [7:0] dirM_r;
  logic [31:0] dirIjkl_r;
  logic [55:0] data_r;
  logic [31:0] rdVal;
  logic privErr;
  logic commit;

  // True for the registers a replacement unit can take over.
  function automatic logic isRepl(input logic [31:0] a);
    isRepl = (a == mpdio_pkg::ADDR_AB_FUNC) ||
            (a == mpdio_pkg::ADDR_AB_DATA) ||
            (a == mpdio_pkg::ADDR_IJKL_DIR) ||
            (a == mpdio_pkg::ADDR_IJKL_FUNC) ||
            (a == mpdio_pkg::ADDR_IJKL_DATA);
  endfunction

  // True for the supervisor-only direction and assignment registers.
  function automatic logic isSuper(input logic [31:0] a);
    isSuper = (a == mpdio_pkg::ADDR_M_DIR) ||
              (a == mpdio_pkg::ADDR_M_FUNC) ||
              (a == mpdio_pkg::ADDR_AB_FUNC) ||
              (a == mpdio_pkg::ADDR_IJKL_DIR) ||
              (a == mpdio_pkg::ADDR_IJKL_FUNC);
  endfunction

  // Byte lane merge of the write data under the strobes.
  function automatic logic [7:0] lane(input logic [7:0] old,
                                      input logic [31:0] wd,
                                      input logic [3:0] st,
                                      input int idx);
    lane = st[idx] ? wd[idx*8 +: 8] : old;
  endfunction

  // Configuration word is caught on the first edge after reset release,
  // since an asynchronous reset may only load constants.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgDone_r <= 1'b0;
      replMode_r <= 1'b0;
    end else if (!cfgDone_r) begin
      cfgDone_r <= 1'b1;
      if (cfgWord[31 - mpdio_pkg::CFG_SRC_BIT]) begin
        replMode_r <= cfgWord[31 - mpdio_pkg::CFG_REPL_BIT];
      end else begin
        replMode_r <= mpdio_pkg::REPL_DEFAULT;
      end
    end
  end

  assign privErr = isSuper(paddr) && !pprot[0];
  assign commit = (state_r == mpdio_pkg::ST_RESP) && localOk_r &&
                  psel && penable && pwrite;

  // Read mux; bit 0 of each register is the most significant bit, and
  // pin 0 of a port sits in bit 7 of its byte in the pin vector.
  always_comb begin
    case (paddr)
      mpdio_pkg::ADDR_M_DIR: rdVal = {dirM_r, 24'h000000};
      mpdio_pkg::ADDR_M_FUNC: rdVal = {func_r[7:0], 24'h000000};
      mpdio_pkg::ADDR_M_DATA: rdVal = {pif.rdVal[7:0], 24'h000000};
      mpdio_pkg::ADDR_AB_FUNC: rdVal = {func_r[15:8], func_r[23:16],
                                        16'h0000};
      mpdio_pkg::ADDR_AB_DATA: rdVal = {pif.rdVal[15:8],
                                        pif.rdVal[23:16], 16'h0000};
      mpdio_pkg::ADDR_IJKL_DIR: rdVal = dirIjkl_r;
      mpdio_pkg::ADDR_IJKL_FUNC: rdVal = {func_r[31:24], func_r[39:32],
                                          func_r[47:40], func_r[55:48]};
      mpdio_pkg::ADDR_IJKL_DATA: rdVal = {pif.rdVal[31:24],
                                          pif.rdVal[39:32],
                                          pif.rdVal[47:40],
                                          pif.rdVal[55:48]};
      default: rdVal = 32'h00000000;
    endcase
  end

  // Access sequencer. A standard register answers in the first access
  // cycle, a replaceable one waits, and in replacement mode the access is
  // handed to the external bus and the local registers stay untouched.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mpdio_pkg::ST_IDLE;
      waitCnt_r <= 2'h0;
      localOk_r <= 1'b0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      extReq_r <= 1'b0;
    end else begin
      case (state_r)
        mpdio_pkg::ST_IDLE: begin
          if (psel && cfgDone_r) begin
            if (replMode_r && isRepl(paddr)) begin
              extReq_r <= 1'b1;
              localOk_r <= 1'b0;
              state_r <= mpdio_pkg::ST_EXT;
            end else if (isRepl(paddr)) begin
              waitCnt_r <= mpdio_pkg::WAIT_REPL - 2'h1;
              localOk_r <= !privErr;
              state_r <= mpdio_pkg::ST_WAIT;
            end else begin
              pready_r <= 1'b1;
              pslverr_r <= privErr;
              prdata_r <= privErr ? 32'h00000000 : rdVal;
              localOk_r <= !privErr;
              state_r <= mpdio_pkg::ST_RESP;
            end
          end
        end
        mpdio_pkg::ST_WAIT: begin
          if (waitCnt_r == 2'h0) begin
            pready_r <= 1'b1;
            pslverr_r <= privErr;
            prdata_r <= privErr ? 32'h00000000 : rdVal;
            state_r <= mpdio_pkg::ST_RESP;
          end else begin
            waitCnt_r <= waitCnt_r - 2'h1;
          end
        end
        mpdio_pkg::ST_EXT: begin
          if (extAck) begin
            extReq_r <= 1'b0;
            pready_r <= 1'b1;
            pslverr_r <= 1'b0;
            prdata_r <= extRdata;
            state_r <= mpdio_pkg::ST_RESP;
          end
        end
        mpdio_pkg::ST_RESP: begin
          pready_r <= 1'b0;
          pslverr_r <= 1'b0;
          localOk_r <= 1'b0;
          state_r <= mpdio_pkg::ST_IDLE;
        end
        default: begin
          state_r <= mpdio_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // External cycle request fields, captured from the setup cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extWrite_r <= 1'b0;
      extAddr_r <= 32'h00000000;
      extWdata_r <= 32'h00000000;
      extStrb_r <= 4'h0;
    end else if (state_r == mpdio_pkg::ST_IDLE && psel && cfgDone_r &&
                 replMode_r && isRepl(paddr)) begin
      extWrite_r <= pwrite;
      extAddr_r <= paddr;
      extWdata_r <= pwdata;
      extStrb_r <= pwrite ? pstrb : 4'h0;
    end
  end

  // Pin assignment registers, one bit per pin.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      func_r <= mpdio_pkg::FUNC_RST;
    end else if (commit) begin
      case (paddr)
        mpdio_pkg::ADDR_M_FUNC: begin
          func_r[7:0] <= lane(func_r[7:0], pwdata, pstrb, 3);
        end
        mpdio_pkg::ADDR_AB_FUNC: begin
          func_r[15:8] <= lane(func_r[15:8], pwdata, pstrb, 3);
          func_r[23:16] <= lane(func_r[23:16], pwdata, pstrb, 2);
        end
        mpdio_pkg::ADDR_IJKL_FUNC: begin
          func_r[31:24] <= lane(func_r[31:24], pwdata, pstrb, 3);
          func_r[39:32] <= lane(func_r[39:32], pwdata, pstrb, 2);
          func_r[47:40] <= lane(func_r[47:40], pwdata, pstrb, 1);
          func_r[55:48] <= lane(func_r[55:48], pwdata, pstrb, 0);
        end
        default: begin
        end
      endcase
    end
  end

  // Direction registers exist only for the bidirectional ports.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dirM_r <= mpdio_pkg::DIR_M_RST;
      dirIjkl_r <= mpdio_pkg::DIR_IJKL_RST;
    end else if (commit) begin
      if (paddr == mpdio_pkg::ADDR_M_DIR) begin
        dirM_r <= lane(dirM_r, pwdata, pstrb, 3);
      end
      if (paddr == mpdio_pkg::ADDR_IJKL_DIR) begin
        dirIjkl_r[31:24] <= lane(dirIjkl_r[31:24], pwdata, pstrb, 3);
        dirIjkl_r[23:16] <= lane(dirIjkl_r[23:16], pwdata, pstrb, 2);
        dirIjkl_r[15:8] <= lane(dirIjkl_r[15:8], pwdata, pstrb, 1);
        dirIjkl_r[7:0] <= lane(dirIjkl_r[7:0], pwdata, pstrb, 0);
      end
    end
  end

  // Data latches take every local write, whatever the pin direction.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_r <= mpdio_pkg::DATA_RST;
    end else if (commit) begin
      case (paddr)
        mpdio_pkg::ADDR_M_DATA: begin
          data_r[7:0] <= lane(data_r[7:0], pwdata, pstrb, 3);
        end
        mpdio_pkg::ADDR_AB_DATA: begin
          data_r[15:8] <= lane(data_r[15:8], pwdata, pstrb, 3);
          data_r[23:16] <= lane(data_r[23:16], pwdata, pstrb, 2);
        end
        mpdio_pkg::ADDR_IJKL_DATA: begin
          data_r[31:24] <= lane(data_r[31:24], pwdata, pstrb, 3);
          data_r[39:32] <= lane(data_r[39:32], pwdata, pstrb, 2);
          data_r[47:40] <= lane(data_r[47:40], pwdata, pstrb, 1);
          data_r[55:48] <= lane(data_r[55:48], pwdata, pstrb, 0);
        end
        default: begin
        end
      endcase
    end
  end

  // Ports A and B always drive when used as discrete pins.
  assign pif.func = func_r;
  assign pif.dir = {dirIjkl_r[7:0], dirIjkl_r[15:8], dirIjkl_r[23:16],
                    dirIjkl_r[31:24], 16'hffff, dirM_r};
  assign pif.dataOut = data_r;

  mpdio_pin_mux u_pins (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pif(pif),
    .pinIn(pinIn),
    .busOut(busOut),
    .busOeN(busOeN),
    .pinOut(pinOut),
    .pinOeN(pinOeN),
    .busIn(busIn)
  );

  // Outputs straight from their flip-flops.
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign replModeActive = replMode_r;
  assign extReq = extReq_r;
  assign extWrite = extWrite_r;
  assign extAddr = extAddr_r;
  assign extWdata = extWdata_r;
  assign extStrb = extStrb_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // Setup is the state-idle cycle with a fresh select.
  logic setupIdle;
  assign setupIdle = (state_r == mpdio_pkg::ST_IDLE) && psel && !penable &&
                     cfgDone_r;

  a_std_two_cycle: assert property (setupIdle && !isRepl(paddr)
    |=> pready) else $error("standard access not two cycles");
  a_three_cycle: assert property (setupIdle && isRepl(paddr)
    && !replMode_r |=> !pready ##1 pready)
    else $error("replaceable access not three cycles");
  a_ext_blocks_local: assert property (setupIdle &&
    isRepl(paddr) && replMode_r |=> extReq && !pready)
    else $error("no external cycle");
  a_priv_refused: assert property (setupIdle && isSuper(paddr)
    && !pprot[0] && !(replMode_r && isRepl(paddr)) ##[1:2] pready
    |-> pslverr) else $error("user access to supervisor register");
  a_reserved_zero: assert property (setupIdle && !pwrite &&
    paddr != mpdio_pkg::ADDR_M_DATA && !isSuper(paddr) && !isRepl(paddr)
    |=> prdata == 32'h00000000) else $error("reserved read not zero");
  // Data reaches the pin whatever the direction; only the enable follows it.
  a_out_drives_pin: assert property (commit && pstrb[3] &&
    paddr == mpdio_pkg::ADDR_M_DATA ##1 func_r[7:0] == 8'h00
    |=> pinOut[7:0] == $past(pwdata[31:24], 2) &&
    pinOeN[7:0] == ~$past(dirM_r)) else $error("latch not on pin");
  a_ab_output_only: assert property (func_r[23:8] == 16'h0000 &&
    $past(func_r[23:8]) == 16'h0000 |-> pinOeN[23:8] == 16'h0000)
    else $error("port A or B not driving");
  a_input_sampled: assert property (func_r[7:0] == 8'h00 &&
    dirM_r == 8'h00 |-> pif.rdVal[7:0] == $past(pinIn[7:0], 2))
    else $error("input not sampled two stages");
  // The first edge after release still shows the reset drivers.
  a_primary_ignores: assert property ($past(rst_n) &&
    func_r == mpdio_pkg::FUNC_RST && $past(func_r) == mpdio_pkg::FUNC_RST
    |-> pinOeN == $past(busOeN) && pinOut == $past(busOut))
    else $error("bus pin disturbed");
  a_cfg_capture: assert property ($rose(cfgDone_r) |->
    replMode_r == ($past(cfgWord[10]) ? $past(cfgWord[6]) :
    mpdio_pkg::REPL_DEFAULT)) else $error("configuration mode misread");

  c_ext_cycle: cover property (extReq ##[1:20] pready);
  c_priv_error: cover property (pready && pslverr);
  c_slow_write: cover property (commit && isRepl(paddr));
endmodule // mpdio_port_top

// [rtl/mpdio_pkg.sv]
package mpdio_pkg;
  // Register byte addresses on the internal bus.
  localparam logic [31:0] ADDR_M_DIR = 32'h8007fc60;
  localparam logic [31:0] ADDR_M_FUNC = 32'h8007fc64;
  localparam logic [31:0] ADDR_M_DATA = 32'h8007fc68;
  localparam logic [31:0] ADDR_AB_FUNC = 32'h8007fc84;
  localparam logic [31:0] ADDR_AB_DATA = 32'h8007fc88;
  localparam logic [31:0] ADDR_IJKL_DIR = 32'h8007fc98;
  localparam logic [31:0] ADDR_IJKL_FUNC = 32'h8007fc9c;
  localparam logic [31:0] ADDR_IJKL_DATA = 32'h8007fca0;
  localparam logic [31:0] ADDR_BLK_LO = 32'h8007fc60;
  localparam logic [31:0] ADDR_BLK_HI = 32'h8007fcff;
  // Pin vector: seven ports of eight pins, port M in the lowest byte.
  localparam int PORT_W = 8;
  localparam int NPIN = 56;
  // Configuration word bit numbers, bit 0 being the most significant.
  localparam int CFG_SRC_BIT = 21;
  localparam int CFG_REPL_BIT = 25;
  localparam logic REPL_DEFAULT = 1'b0;
  // Reset values: pins start on their bus function, latches cleared.
  localparam logic [55:0] FUNC_RST = 56'hff_ffff_ffff_ffff;
  localparam logic [7:0] DIR_M_RST = 8'h00;
  localparam logic [31:0] DIR_IJKL_RST = 32'h0000_0000;
  localparam logic [55:0] DATA_RST = 56'h00_0000_0000_0000;
  // Access lengths in clock cycles, setup cycle included.
  localparam int ACC_CYC_STD = 2;
  localparam int ACC_CYC_REPL = 3;
  localparam logic [1:0] WAIT_REPL = 2'(ACC_CYC_REPL - ACC_CYC_STD);
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_EXT,
    ST_RESP
  } mpdio_state_e;
endpackage

// [rtl/mpdio_pin_if.sv]
`timescale 1ns/1ns
// Per-pin configuration going to the pin logic and values coming back.
interface mpdio_pin_if;
  logic [55:0] func;
  logic [55:0] dir;
  logic [55:0] dataOut;
  logic [55:0] rdVal;
  modport ctrl(output func, output dir, output dataOut, input rdVal);
  modport pins(input func, input dir, input dataOut, output rdVal);
endinterface

// [rtl/mpdio_pin_mux.sv]
`timescale 1ns/1ns
module mpdio_pin_mux (
  input wire logic core_clk,
  input wire logic rst_n,
  mpdio_pin_if.pins pif,
  input wire logic [55:0] pinIn,
  input wire logic [55:0] busOut,
  input wire logic [55:0] busOeN,
  output logic [55:0] pinOut,
  output logic [55:0] pinOeN,
  output logic [55:0] busIn
);
  logic [55:0] sync1_r;
  logic [55:0] sync2_r;
  logic [55:0] pinOut_r;
  logic [55:0] pinOeN_r;

  // Two-stage sampler; only the second stage is used anywhere.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
    end
  end

  // Registered pin drivers, so a configuration change reaches the pin one
  // cycle after the register; bus values pass the same flop, so port and bus timing match here.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut_r <= '0;
      pinOeN_r <= '1;
    end else begin
      pinOut_r <= (pif.func & busOut) | (~pif.func & pif.dataOut);
      pinOeN_r <= (pif.func & busOeN) | (~pif.func & ~pif.dir);
    end
  end

  // Discrete inputs read the pin, everything else reads the latch.
  assign pif.rdVal = (~pif.func & ~pif.dir & sync2_r) |
                     ((pif.func | pif.dir) & pif.dataOut);
  assign pinOut = pinOut_r;
  assign pinOeN = pinOeN_r;
  assign busIn = sync2_r;
endmodule // mpdio_pin_mux

// [sim/mpdio_ext_model.sv]
`timescale 1ns/1ns
// Stand-in for the external replacement unit on the forwarded port cycle.
module mpdio_ext_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [3:0] lat,
  input wire logic extReq,
  input wire logic extWrite,
  input wire logic [31:0] extAddr,
  input wire logic [31:0] extWdata,
  output logic extAck,
  output logic [31:0] extRdata,
  output logic [31:0] lastWdata
);
  logic [3:0] waitCnt_r;

  // Answer after lat waiting edges; read data flips outside the ack so a
  // stale sample never passes for a real answer.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      extAck <= 1'b0;
      waitCnt_r <= 4'h0;
      extRdata <= 32'h0000_0000;
      lastWdata <= 32'h0000_0000;
    end else if (extReq && !extAck && waitCnt_r == lat) begin
      extAck <= 1'b1;
      extRdata <= extAddr ^ 32'h0f0f_0000;
      if (extWrite) begin
        lastWdata <= extWdata;
      end
    end else begin
      extAck <= 1'b0;
      extRdata <= ~extRdata;
      waitCnt_r <= (extReq && !extAck) ? waitCnt_r + 4'h1 : 4'h0;
    end
  end
endmodule // mpdio_ext_model

// [sim/mpdio_port_top_bench.sv]
`timescale 1ns/1ns
module mpdio_port_top_bench;
  logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, serr;
  logic replModeActive, extReq, extWrite, extAck;
  logic [31:0] paddr, pwdata, prdata, cfgWord, rdat;
  logic [31:0] extAddr, extWdata, extRdata, lastWdata;
  logic [3:0] pstrb, extStrb, lat;
  logic [2:0] pprot;
  logic [55:0] pinIn, pinOut, pinOeN, busOut, busOeN, busIn;
  int ncyc, err_total, checks, nFast;

  mpdio_port_top u_mpdio_port_top (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pprot(pprot), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfgWord(cfgWord), .replModeActive(replModeActive), .extReq(extReq),
    .extWrite(extWrite), .extAddr(extAddr), .extWdata(extWdata),
    .extStrb(extStrb), .extAck(extAck), .extRdata(extRdata),
    .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN), .busOut(busOut),
    .busOeN(busOeN), .busIn(busIn)
  );

  mpdio_ext_model u_mpdio_ext_model (
    .core_clk(core_clk), .rst_n(rst_n), .lat(lat), .extReq(extReq),
    .extWrite(extWrite), .extAddr(extAddr), .extWdata(extWdata),
    .extAck(extAck), .extRdata(extRdata), .lastWdata(lastWdata)
  );

  // Free-running core clock at 10 MHz.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] seen,
                     input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  // The cycle count includes the setup cycle.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d, input logic [2:0] pr);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= pr;
    @(posedge core_clk);
    penable <= 1'b1;
    ncyc = 1;
    do begin
      @(posedge core_clk);
      ncyc++;
      if (ncyc > 40) begin
        err_total++;
        tally_and_finish();
      end
    end while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 3'h1);
  endtask

  task automatic rdchk(input string what, input logic [31:0] a,
                       input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 3'h1);
    chk(what, rdat, exp);
  endtask

  // Reset is asynchronous; the word must be stable at the first edge after.
  task automatic do_reset(input logic [31:0] cfg);
    rst_n <= 1'b0;
    cfgWord <= cfg;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
  endtask

  // Reset values, access lengths and the holes in the map.
  task automatic t_map();
    rdchk("m dir", mpdio_pkg::ADDR_M_DIR, 32'h0000_0000);
    chk("m cycles", ncyc, 2);
    rdchk("m func", mpdio_pkg::ADDR_M_FUNC, 32'hff00_0000);
    rdchk("ab func", mpdio_pkg::ADDR_AB_FUNC, 32'hffff_0000);
    chk("ab cycles", ncyc, 3);
    rdchk("ijkl func", mpdio_pkg::ADDR_IJKL_FUNC, 32'hffff_ffff);
    chk("ijkl cycles", ncyc, 3);
    rdchk("ijkl dir", mpdio_pkg::ADDR_IJKL_DIR, 32'h0000_0000);
    wr(32'h8007fc80, 32'hffff_ffff);
    rdchk("no ab dir", 32'h8007fc80, 32'h0000_0000);
    chk("hole cycles", ncyc, 2);
    rdchk("ab kept", mpdio_pkg::ADDR_AB_FUNC, 32'hffff_0000);
  endtask

  // User mode may touch data only.
  task automatic t_priv();
    apb(1'b1, mpdio_pkg::ADDR_M_DIR, 32'hffff_ffff, 3'h0);
    chk("user m dir", serr, 1'b1);
    apb(1'b1, mpdio_pkg::ADDR_AB_FUNC, 32'h0000_0000, 3'h0);
    chk("user ab func", serr, 1'b1);
    apb(1'b1, mpdio_pkg::ADDR_IJKL_DIR, 32'hffff_ffff, 3'h0);
    chk("user ijkl dir", serr, 1'b1);
    apb(1'b1, mpdio_pkg::ADDR_M_DATA, 32'h5a00_0000, 3'h0);
    chk("user m data", serr, 1'b0);
    rdchk("m dir kept", mpdio_pkg::ADDR_M_DIR, 32'h0000_0000);
    rdchk("ab func kept", mpdio_pkg::ADDR_AB_FUNC, 32'hffff_0000);
    rdchk("m latch", mpdio_pkg::ADDR_M_DATA, 32'h5a00_0000);
  endtask

  // Port M: upper four pins out, lower four in, then back to bus use.
  task automatic t_port_m();
    wr(mpdio_pkg::ADDR_M_FUNC, 32'h0000_0000);
    // Pins change while all eight are inputs, long before the read, so only the settled value shows.
    pinIn[7:0] <= 8'h3c;
    wr(mpdio_pkg::ADDR_M_DIR, 32'hf000_0000);
    wr(mpdio_pkg::ADDR_M_DATA, 32'ha500_0000);
    repeat (3) @(posedge core_clk);
    chk("m oe", pinOeN[7:0], 8'h0f);
    chk("m out", pinOut[7:4], 4'ha);
    rdchk("m read", mpdio_pkg::ADDR_M_DATA, 32'hac00_0000);
    wr(mpdio_pkg::ADDR_M_FUNC, 32'hff00_0000);
    repeat (3) @(posedge core_clk);
    chk("m bus out", pinOut[7:0], busOut[7:0]);
    chk("m bus oe", pinOeN[7:0], busOeN[7:0]);
    chk("bus in", busIn, pinIn);
  endtask

  // Ports A and B drive as soon as they leave bus use; lanes gate bytes.
  task automatic t_port_ab();
    wr(mpdio_pkg::ADDR_AB_FUNC, 32'h0000_0000);
    wr(mpdio_pkg::ADDR_AB_DATA, 32'h1234_0000);
    repeat (3) @(posedge core_clk);
    chk("ab oe", pinOeN[23:8], 16'h0000);
    chk("ab out", pinOut[23:8], 16'h3412);
    pstrb <= 4'h4;
    wr(mpdio_pkg::ADDR_AB_DATA, 32'hffff_0000);
    pstrb <= 4'hf;
    repeat (3) @(posedge core_clk);
    chk("ab lane", pinOut[23:8], 16'hff12);
  endtask

  // Ports I and J out, K and L in.
  task automatic t_port_ijkl();
    wr(mpdio_pkg::ADDR_IJKL_FUNC, 32'h0000_0000);
    wr(mpdio_pkg::ADDR_IJKL_DIR, 32'hffff_0000);
    wr(mpdio_pkg::ADDR_IJKL_DATA, 32'h1122_3344);
    pinIn[55:40] <= 16'h6f5e;
    repeat (3) @(posedge core_clk);
    chk("ijkl oe", pinOeN[55:24], 32'hffff_0000);
    chk("ijkl out", pinOut[39:24], 16'h2211);
    rdchk("ijkl read", mpdio_pkg::ADDR_IJKL_DATA, 32'h1122_5e6f);
  endtask

  // Replacement mode forwards A, B, I-L; a quick and a slow far side.
  task automatic t_replace();
    do_reset(32'h0000_0440);
    chk("repl on", replModeActive, 1'b1);
    lat <= 4'h0;
    rdchk("ext read", mpdio_pkg::ADDR_AB_DATA,
          mpdio_pkg::ADDR_AB_DATA ^ 32'h0f0f_0000);
    chk("ext rd strb", extStrb, 4'h0);
    chk("ext rd dir", extWrite, 1'b0);
    nFast = ncyc;
    lat <= 4'h5;
    wr(mpdio_pkg::ADDR_IJKL_FUNC, 32'h00c3_0000);
    chk("ext wdata", lastWdata, 32'h00c3_0000);
    chk("ext wr strb", extStrb, 4'hf);
    chk("ext wr dir", extWrite, 1'b1);
    chk("ext addr", extAddr, mpdio_pkg::ADDR_IJKL_FUNC);
    chk("ext slow", ncyc - nFast, 5);
    repeat (3) @(posedge core_clk);
    chk("local kept", pinOut[55:24], busOut[55:24]);
    rdchk("m local", mpdio_pkg::ADDR_M_FUNC, 32'hff00_0000);
    chk("m local cyc", ncyc, 2);
    do_reset(32'h0000_0040);
    chk("repl default", replModeActive, 1'b0);
    rdchk("ab local", mpdio_pkg::ADDR_AB_FUNC, 32'hffff_0000);
    chk("ab local cyc", ncyc, 3);
  endtask

  // Main sequence; every input has a value at time zero.
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hf;
    pprot = 3'h1;
    cfgWord = 32'h0000_0000;
    lat = 4'h0;
    pinIn = 56'h96_a5c3_0f81_7e24;
    busOut = 56'h01_2345_6789_abcd;
    busOeN = 56'h55_aa55_aa55_aa55;
    err_total = 0;
    checks = 0;
    do_reset(32'h0000_0000);
    t_map();
    t_priv();
    t_port_m();
    t_port_ab();
    t_port_ijkl();
    t_replace();
    tally_and_finish();
  end
endmodule // mpdio_port_top_bench
